// ---- core/ssdc_pkg.sv ----
// constants and carrier types for the seek servo digital control core
package ssdc_pkg;

    // ****************************************
    // counter geometry and decode thresholds
    // ****************************************
    localparam int           CNT_W           = 9;
    localparam int           DAC_W           = 5;
    localparam logic [8:0]   CNT_RST         = 9'h1ff;  // complement of zero tracks
    localparam logic [8:0]   CNT_STEP        = 9'h001;
    localparam logic [8:0]   LOW_GAIN_TRACKS = 9'h040;  // 64
    localparam logic [8:0]   CLAMP_TRACKS    = 9'h020;  // 32
    localparam logic [8:0]   LAST_TRACK      = 9'h001;
    localparam logic [8:0]   NO_TRACK        = 9'h000;

    // ****************************************
    // settle delay before on cylinder
    // ****************************************
    localparam int           CLK_PERIOD_NS   = 10;
    localparam real          SETTLE_TIME_MS  = 1.75;
    localparam int           SETTLE_CYCLES   = int'($ceil(SETTLE_TIME_MS * 1.0e6 / real'(CLK_PERIOD_NS)));
    localparam int           SETTLE_W        = 18;
    localparam logic [17:0]  SETTLE_RST      = 18'h0_0000;

    // ****************************************
    // switch controls toward the analog loop
    // ****************************************
    typedef struct packed {
        logic             low_gain_en;   // low resistance feedback path on
        logic             pos_clamp;     // position converter clamped at max
        logic             dac_en;        // stepped position error from dac
        logic [DAC_W-1:0] dac_code;      // five low counter bits
        logic             integ_clamp;   // velocity integrator held at zero
        logic             coarse_gate;
        logic             fine_gate;     // higher gain velocity path too
    } ssdc_switch_s;

    // reset pattern equals the decode of a zero-track count, so nothing toggles when reset lifts
    localparam ssdc_switch_s SWITCH_RST = '{low_gain_en: 1'b1, pos_clamp: 1'b0, dac_en: 1'b0,
                                            dac_code: 5'h1f, integ_clamp: 1'b1, coarse_gate: 1'b0,
                                            fine_gate: 1'b1};

endpackage

// ---- core/ssdc_seek_servo.sv ----
// digital control core of the voice-coil seek servo
module ssdc_seek_servo #(
    parameter int SETTLE_CYCLES = ssdc_pkg::SETTLE_CYCLES
) (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         resetn,
    // difference transfer from the controller
    input  wire logic                         diff_load,
    input  wire logic [ssdc_pkg::CNT_W-1:0]   diff_value,
    input  wire logic                         target_odd,
    // motion status
    input  wire logic                         any_seek,
    input  wire logic                         cyl_pulse,
    input  wire logic                         fine_zero,
    // head load and unload sequencing
    input  wire logic                         heads_unloaded,
    input  wire logic                         load_start,
    input  wire logic                         power_off_unload,
    // analog loop switch controls, head drives, parity flag and on cylinder status
    output ssdc_pkg::ssdc_switch_s            sw,
    output logic                              retract_drive,
    output logic                              forward_drive,
    output logic                              vel_amp_disable,
    output logic                              target_parity_flag,
    output logic                              on_cylinder,
    // counter view
    output logic [ssdc_pkg::CNT_W-1:0]        diff_count
);

    // ****************************************
    // decode helpers
    // ****************************************
    // tracks remaining is simply the complement of the counter
    function automatic logic [8:0] remaining(input logic [8:0] cnt);
        remaining = ~cnt;
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [8:0]              cnt_reg;
    logic [8:0]              cnt_next;
    ssdc_pkg::ssdc_switch_s  sw_reg;
    ssdc_pkg::ssdc_switch_s  sw_next;
    logic                    parity_reg;
    logic                    retract_reg;
    logic                    forward_reg;
    logic                    vdis_reg;
    logic [17:0]             settle_reg;
    logic [17:0]             settle_next;
    logic                    oncyl_reg;
    logic                    oncyl_next;

    // ****************************************
    // decode of the difference counter
    // ****************************************
    wire logic [8:0] tracks_left = remaining(cnt_reg);
    wire logic       under_64    = tracks_left < ssdc_pkg::LOW_GAIN_TRACKS;
    wire logic       over_32     = tracks_left > ssdc_pkg::CLAMP_TRACKS;
    wire logic       last_32     = !over_32 && tracks_left != ssdc_pkg::NO_TRACK;
    wire logic       one_left    = tracks_left <= ssdc_pkg::LAST_TRACK;
    wire logic       at_target   = cnt_reg == ssdc_pkg::CNT_RST;
    // counting halts at target so a stray pulse cannot wrap the count
    wire logic       count_step  = any_seek && cyl_pulse && !at_target;

    // ****************************************
    // counter next value, load wins over a pulse
    // ****************************************
    assign cnt_next = diff_load  ? diff_value :
                      count_step ? cnt_reg + ssdc_pkg::CNT_STEP :
                                   cnt_reg;

    // ****************************************
    // switch controls from the decode
    // ****************************************
    assign sw_next.low_gain_en = under_64;
    assign sw_next.pos_clamp   = over_32;
    assign sw_next.dac_en      = last_32 && !one_left;
    assign sw_next.dac_code    = cnt_reg[ssdc_pkg::DAC_W-1:0];
    // the pulse itself dumps the integrator so each step starts a fresh ramp
    assign sw_next.integ_clamp = !(any_seek && last_32 && !cyl_pulse);
    assign sw_next.coarse_gate = !one_left;
    assign sw_next.fine_gate   = one_left;

    // ****************************************
    // settle timer, restarts whenever the null is lost
    // ****************************************
    wire logic settling = sw_reg.fine_gate && fine_zero && !diff_load;
    wire logic settled  = settle_reg == 18'(SETTLE_CYCLES - 1);
    assign settle_next = !settling ? ssdc_pkg::SETTLE_RST :
                         settled   ? settle_reg :
                                     settle_reg + 18'h0_0001;
    assign oncyl_next  = settling && settled;

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_reg     <= ssdc_pkg::CNT_RST;
            sw_reg      <= ssdc_pkg::SWITCH_RST;
            parity_reg  <= 1'b0;
            retract_reg <= 1'b1;
            forward_reg <= 1'b0;
            vdis_reg    <= 1'b0;
            settle_reg  <= ssdc_pkg::SETTLE_RST;
            oncyl_reg   <= 1'b0;
        end else begin
            cnt_reg     <= cnt_next;
            sw_reg      <= sw_next;
            settle_reg  <= settle_next;
            oncyl_reg   <= oncyl_next;
            if (diff_load) begin
                parity_reg <= target_odd;
            end
            retract_reg <= heads_unloaded && !load_start;
            forward_reg <= load_start;
            vdis_reg    <= power_off_unload;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign sw                 = sw_reg;
    assign retract_drive      = retract_reg;
    assign forward_drive      = forward_reg;
    assign vel_amp_disable    = vdis_reg;
    assign target_parity_flag = parity_reg;
    assign on_cylinder        = oncyl_reg;
    assign diff_count         = cnt_reg;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_pulse_counts;
        any_seek && cyl_pulse && !diff_load && cnt_reg != ssdc_pkg::CNT_RST;
    endsequence

    sequence s_loaded;
        diff_load;
    endsequence

    property p_count_inc;
        s_pulse_counts |=> cnt_reg == $past(cnt_reg) + ssdc_pkg::CNT_STEP;
    endproperty
    a_count_inc: assert property (p_count_inc) else $error("counter missed a cylinder pulse");

    property p_load;
        s_loaded |=> cnt_reg == $past(diff_value) && target_parity_flag == $past(target_odd);
    endproperty
    a_load: assert property (p_load) else $error("difference transfer not taken");

    property p_low_gain;
        ##1 sw.low_gain_en == (~$past(cnt_reg) < 9'h040);
    endproperty
    a_low_gain: assert property (p_low_gain) else $error("low gain path wrong for count");

    property p_clamp_vs_dac;
        sw.pos_clamp |-> !sw.dac_en && !sw.fine_gate && sw.integ_clamp;
    endproperty
    a_clamp_vs_dac: assert property (p_clamp_vs_dac) else $error("clamp overlaps dac region");

    property p_dac_code;
        ##1 sw.dac_en |-> sw.dac_code == $past(cnt_reg[4:0]) && $past(cnt_reg) inside {[9'h1df:9'h1fd]};
    endproperty
    a_dac_code: assert property (p_dac_code) else $error("dac driven outside last tracks");

    property p_integ_pulse;
        cyl_pulse |=> sw.integ_clamp;
    endproperty
    a_integ_pulse: assert property (p_integ_pulse) else $error("integrator open across a pulse");

    property p_fine_gate;
        sw.fine_gate |-> !sw.coarse_gate && !sw.dac_en && !sw.low_gain_en == 1'b0;
    endproperty
    a_fine_gate: assert property (p_fine_gate) else $error("fine and coarse gates overlap");

    property p_unload;
        power_off_unload |=> vel_amp_disable;
    endproperty
    a_unload: assert property (p_unload) else $error("velocity amplifier not disabled");

    property p_retract;
        heads_unloaded && !load_start |=> retract_drive && !forward_drive;
    endproperty
    a_retract: assert property (p_retract) else $error("retract not held while unloaded");

    property p_override;
        load_start |=> forward_drive && !retract_drive;
    endproperty
    a_override: assert property (p_override) else $error("forward drive did not override");

    property p_oncyl_needs_null;
        on_cylinder |-> $past(fine_zero) && settle_reg == 18'(SETTLE_CYCLES - 1);
    endproperty
    a_oncyl_needs_null: assert property (p_oncyl_needs_null) else $error("on cylinder before settle");

    property p_null_lost;
        !fine_zero |=> !on_cylinder ##1 !on_cylinder;
    endproperty
    a_null_lost: assert property (p_null_lost) else $error("on cylinder kept after null lost");

endmodule

// ---- verif/ssdc_servo_model.sv ----
// behavioural model of the analog servo side: cylinder pulses and fine null detector
module ssdc_servo_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // requests from the bench
    input  wire logic step,
    input  wire logic stopped,
    // loop state from the core
    input  wire logic fine_gate,
    // transducer outputs
    output logic      cyl_pulse,
    output logic      fine_zero
);
    timeunit 1ns;
    timeprecision 100ps;
    // one crossing per request, never stretched, so each pulse counts once;
    // null is only seen once the fine path is switched in
    always_ff @(posedge clk) begin
        cyl_pulse <= resetn & step;
        fine_zero <= resetn & stopped & fine_gate;
    end
endmodule

// ---- verif/test_seek_servo_digital_control.sv ----
// self-checking bench for the seek servo digital control core
module test_seek_servo_digital_control;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // signals and instances
    // ****************************************
    localparam int SETTLE = 20;  // short settle keeps the run brief
    logic clk = 1'b0, resetn = 1'b0, diff_load = 1'b0, target_odd = 1'b0, any_seek = 1'b0;
    logic heads_unloaded = 1'b0, load_start = 1'b0, power_off_unload = 1'b0, step = 1'b0, stopped = 1'b0;
    logic [8:0] diff_value = 9'h000, diff_count;
    logic cyl_pulse, fine_zero, retract_drive, forward_drive, vel_amp_disable, target_parity_flag, on_cylinder;
    ssdc_pkg::ssdc_switch_s sw;
    int errors = 0, comparisons = 0;
    always #5 clk = ~clk;
    ssdc_seek_servo #(.SETTLE_CYCLES(SETTLE)) ssdc_seek_servo_inst (.clk(clk), .resetn(resetn),
        .diff_load(diff_load), .diff_value(diff_value), .target_odd(target_odd), .any_seek(any_seek),
        .cyl_pulse(cyl_pulse), .fine_zero(fine_zero), .heads_unloaded(heads_unloaded),
        .load_start(load_start), .power_off_unload(power_off_unload), .sw(sw), .retract_drive(retract_drive),
        .forward_drive(forward_drive), .vel_amp_disable(vel_amp_disable),
        .target_parity_flag(target_parity_flag), .on_cylinder(on_cylinder), .diff_count(diff_count));
    ssdc_servo_model ssdc_servo_model_inst (.clk(clk), .resetn(resetn), .step(step), .stopped(stopped),
        .fine_gate(sw.fine_gate), .cyl_pulse(cyl_pulse), .fine_zero(fine_zero));
    // ****************************************
    // compare and helper tasks
    // ****************************************
    task automatic chk_v(input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic chk_sw(input ssdc_pkg::ssdc_switch_s got, input ssdc_pkg::ssdc_switch_s exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: switches %h, wanted %h", $time, got, exp);
        end
    endtask
    // expected switch pattern for a number of tracks left, seek active, no pulse
    function automatic ssdc_pkg::ssdc_switch_s decode(input int left);
        ssdc_pkg::ssdc_switch_s s;
        logic [8:0] cnt;
        cnt = ~9'(left);
        s.low_gain_en = (left < 64);
        s.pos_clamp = (left > 32);
        s.dac_en = (left >= 2) && (left <= 32);
        s.dac_code = cnt[4:0];
        s.integ_clamp = !((left >= 1) && (left <= 32));
        s.fine_gate = (left <= 1);
        s.coarse_gate = (left > 1);
        return s;
    endfunction
    task automatic final_report();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_reset();
        repeat (16) @(posedge clk);
        #1;
        chk_sw(sw, ssdc_pkg::SWITCH_RST);
        chk_v(diff_count, ssdc_pkg::CNT_RST);
        chk_v(9'({retract_drive, forward_drive, vel_amp_disable, on_cylinder}), 9'h008);
        @(posedge clk);
        resetn <= 1'b1;
        $display("test reset done");
    endtask
    task automatic test_heads();
        @(posedge clk);
        heads_unloaded <= 1'b1;
        power_off_unload <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk_v(9'({retract_drive, forward_drive, vel_amp_disable}), 9'h005);
        @(posedge clk);
        load_start <= 1'b1;
        power_off_unload <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk_v(9'({retract_drive, forward_drive, vel_amp_disable}), 9'h002);
        @(posedge clk);
        load_start <= 1'b0;
        heads_unloaded <= 1'b0;
        $display("test heads done");
    endtask
    // load a seek, try a pulse while idle, then walk every track down to null
    task automatic test_seek(input int len, input logic odd);
        int n;
        @(posedge clk);
        diff_load <= 1'b1;
        diff_value <= ~9'(len);
        target_odd <= odd;
        @(posedge clk);
        diff_load <= 1'b0;
        step <= 1'b1;
        @(posedge clk);
        step <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk_v(diff_count, ~9'(len));
        chk_v(9'(target_parity_flag), 9'(odd));
        @(posedge clk);
        any_seek <= 1'b1;
        for (int left = len; left >= 0; left--) begin
            repeat (4) @(posedge clk);
            #1 chk_sw(sw, decode(left));
            chk_v(diff_count, ~9'(left));
            if (left > 0) begin
                @(posedge clk);
                step <= 1'b1;
                @(posedge clk);
                step <= 1'b0;
            end
        end
        @(posedge clk);
        stopped <= 1'b1;
        repeat (SETTLE) @(posedge clk);
        #1 chk_v(9'(on_cylinder), 9'h000);
        n = 0;
        while (on_cylinder !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1 n++;
        end
        chk_v(9'(on_cylinder), 9'h001);
        if (n == 10) final_report();
        @(posedge clk);
        stopped <= 1'b0;
        any_seek <= 1'b0;
        $display("test seek %0d done", len);
    endtask
    initial begin
        test_reset();
        test_heads();
        test_seek(70, 1'b1);
        test_seek(33, 1'b0);
        final_report();
    end
endmodule
